// ### hdl/pfs_map.svh
// Opcodes, field codes and timing constants of the flow sequencer
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

// Flow-control opcodes
`define PFS_OP_COND_JUMP 8'h15
`define PFS_OP_JUMP_ALWAYS 8'h16
`define PFS_OP_CALL_SUB 8'h17
`define PFS_OP_RETURN_SUB 8'h18
`define PFS_OP_WAIT 8'h1b

// Wait condition codes in the type field
`define PFS_WAIT_TICKS 8'h00
`define PFS_WAIT_POS 8'h01
`define PFS_WAIT_REF_SWITCH 8'h02
`define PFS_WAIT_LIMIT_SWITCH 8'h03
`define PFS_WAIT_REF_SEARCH 8'h04

// Conditional jump code that tests the timeout error flag
`define PFS_COND_TIMEOUT 8'h08

// Value field that selects the accumulator as tick source
`define PFS_VALUE_ACCUM 32'hffffffff

// Return stack depth
`define PFS_STACK_DEPTH 8

// Tick timebase: period in ms, clock in kHz, cycles per tick
`define PFS_TICK_MS 10
`define PFS_CLK_KHZ 100000
`define PFS_TICK_CYCLES (`PFS_TICK_MS * `PFS_CLK_KHZ)

// Reset values
`define PFS_PC_RESET 32'h00000000

`endif

// ### hdl/pfs_pkg.sv
// Types shared by the flow sequencer modules
package pfs_pkg;

    // Sequencer operating mode
    typedef enum logic {PFS_IDLE, PFS_WAIT} pfs_mode_e;

    // Program counter and command value word
    typedef logic [31:0] pfs_word_t;

endpackage

// ### hdl/pfs_return_stack.sv
// Return address stack for subroutine calls
`timescale 1ns/1ps
`default_nettype none
module pfs_return_stack #(
    parameter int unsigned DEPTH = 8,
    parameter int unsigned WIDTH = 32
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic push, // Push pushData
    input wire logic [WIDTH-1:0] pushData, // Word to save
    input wire logic pop, // Drop the top entry
    output logic [WIDTH-1:0] top, // Most recent entry
    output logic [$clog2(DEPTH):0] depth, // Entries held
    output logic full, // No space left
    output logic empty // Nothing saved
);
    import pfs_pkg::*;

    localparam int unsigned DW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [DW:0] depth;
    } pfs_stack_s;

    pfs_stack_s st;
    pfs_stack_s next_st;

    // Push and pop are refused at the limits so depth never wraps
    always_comb
    begin
        next_st = st;
        if (push && !full)
        begin
            next_st.mem[st.depth[DW-1:0]] = pushData;
            next_st.depth = st.depth + (DW+1)'(1);
        end
        else if (pop && !empty)
        begin
            next_st.depth = st.depth - (DW+1)'(1);
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    // Status and top word
    assign full = (st.depth == (DW+1)'(DEPTH));
    assign empty = (st.depth == '0);
    assign depth = st.depth;
    assign top = st.mem[DW'(st.depth - (DW+1)'(1))];
endmodule
`default_nettype wire

// ### hdl/pfs_sequencer.sv
// Program flow sequencer: jump, call, return and wait commands
//
// How it works
// - Flow commands act only in standalone mode; host commands change nothing.
// - Jump-always loads the program counter from the value field.
// - Call pushes the program counter then loads the subroutine address.
// - The return stack holds exactly eight entries.
// - A call with a full stack changes neither stack nor counter.
// - Return pops the newest entry and resumes after the call.
// - Return with an empty stack changes neither counter nor stack.
// - Wait opcode type field picks ticks, position, ref, limit or search.
// - During a wait the counter holds until condition or timeout, then steps.
// - Tick wait stalls until the given tick count has elapsed.
// - One tick every ten milliseconds for delays and timeouts.
// - Position wait ends when the selected axis reaches its target.
// - Reference wait ends when the selected axis reference switch triggers.
// - Limit wait ends when either limit switch of the axis triggers.
// - Search wait ends when the selected axis finishes reference search.
// - Axis waits use the value as tick timeout; zero waits forever.
// - Value minus one takes the accumulator as count or timeout.
// - Timeout end sets a sticky error flag until clear-error.
// - Conditional jump code eight branches when the error flag is set.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_map.svh"
module pfs_sequencer #(
    parameter int unsigned AXES = 4,
    parameter int unsigned TICK_CYCLES = `PFS_TICK_CYCLES
) (
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic standalone, // High while running a stored program
    input wire logic cmdValid, // Command present
    input wire logic [7:0] cmdOpcode, // Instruction number
    input wire logic [7:0] cmdType, // Type field
    input wire logic [7:0] cmdMotor, // Motor/bank field
    input wire pfs_pkg::pfs_word_t cmdValue, // Value field
    input wire pfs_pkg::pfs_word_t accum, // Accumulator contents
    input wire logic clearError, // Clear-error pulse
    input wire logic [AXES-1:0] targetReached, // Axis at target
    input wire logic [AXES-1:0] refSwitch, // Reference switch
    input wire logic [AXES-1:0] limitLeft, // Left limit switch
    input wire logic [AXES-1:0] limitRight, // Right limit switch
    input wire logic [AXES-1:0] refSearchDone, // Reference search over
    output pfs_pkg::pfs_word_t pc, // Program counter
    output logic cmdDone, // Command finished pulse
    output logic waitBusy, // Wait in progress
    output logic timeoutErrorFlag // Sticky timeout error
);
    import pfs_pkg::*;

    localparam int unsigned SW = 5 * AXES;
    localparam int unsigned DEPTH = `PFS_STACK_DEPTH;
    localparam int unsigned DW = $clog2(DEPTH);

    typedef struct packed {
        pfs_mode_e mode;
        logic [SW-1:0] sync1;
        logic [SW-1:0] sync2;
        pfs_word_t pc;
        logic done;
        logic busy;
        logic timeoutErr;
        logic [7:0] waitType;
        logic [7:0] waitMotor;
        pfs_word_t waitCount;
        pfs_word_t tickCount;
    } pfs_seq_s;

    pfs_seq_s st;
    pfs_seq_s next_st;

    logic tick;
    logic tickRestart;
    logic stackPush;
    logic stackPop;
    pfs_word_t stackTop;
    logic [DW:0] stackDepth;
    logic stackFull;
    logic stackEmpty;
    logic accept;
    logic axisOk;
    logic [AXES-1:0] selMask;
    logic condMet;
    logic ticksReached;
    pfs_word_t cmdCount;

    //------------------------------------------------------------
    // Submodules
    //------------------------------------------------------------

    // Tick divider, restarted at each wait start
    // divided clock tick
    pfs_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(tickRestart),
        .tick(tick)
    );

    // Eight-entry return stack
    // eight entry stack
    pfs_return_stack #(
        .DEPTH(DEPTH),
        .WIDTH(32)
    ) u_stack (
        .sys_clk(sys_clk),
        .rst(rst),
        .push(stackPush),
        .pushData(st.pc),
        .pop(stackPop),
        .top(stackTop),
        .depth(stackDepth),
        .full(stackFull),
        .empty(stackEmpty)
    );

    //------------------------------------------------------------
    // Decode helpers
    //------------------------------------------------------------

    // Axis status after synchronising; unknown axis never meets
    assign axisOk = (st.waitMotor < 8'(AXES));
    assign selMask = axisOk ? (AXES'(1) << st.waitMotor) : '0;
    assign ticksReached = (st.tickCount >= st.waitCount);
    assign accept = cmdValid && (st.mode == PFS_IDLE);

    // Count source for a new wait
    // accumulator as count
    assign cmdCount = (cmdValue == `PFS_VALUE_ACCUM) ? accum : cmdValue;

    // Condition of the wait in progress
    always_comb
    begin
        condMet = 1'b0;
        unique case (st.waitType)
            `PFS_WAIT_POS:
                condMet = |(st.sync2[4*AXES +: AXES] & selMask);
            `PFS_WAIT_REF_SWITCH:
                condMet = |(st.sync2[3*AXES +: AXES] & selMask);
            `PFS_WAIT_LIMIT_SWITCH:
                condMet = |((st.sync2[2*AXES +: AXES]
                    | st.sync2[AXES +: AXES]) & selMask);
            `PFS_WAIT_REF_SEARCH:
                condMet = |(st.sync2[0 +: AXES] & selMask);
            default:
                condMet = 1'b0;
        endcase
    end

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------

    // Pins pass two flops; commands act only in the idle mode
    always_comb
    begin
        next_st = st;
        next_st.sync1 = {targetReached, refSwitch, limitLeft, limitRight,
            refSearchDone};
        next_st.sync2 = st.sync1;
        next_st.done = 1'b0;
        tickRestart = 1'b0;
        stackPush = 1'b0;
        stackPop = 1'b0;
        // Clear first so a timeout in the same cycle still wins
        if (clearError)
            next_st.timeoutErr = 1'b0;
        unique case (st.mode)
            PFS_IDLE:
            begin
                if (accept && standalone)
                begin
                    next_st.done = 1'b1;
                    next_st.pc = st.pc + 32'h00000001;
                    unique case (cmdOpcode)
                        `PFS_OP_JUMP_ALWAYS:
                            next_st.pc = cmdValue;
                        `PFS_OP_CALL_SUB:
                        begin
                            if (stackFull)
                                next_st.pc = st.pc;
                            else
                            begin
                                stackPush = 1'b1;
                                next_st.pc = cmdValue;
                            end
                        end
                        `PFS_OP_RETURN_SUB:
                        begin
                            if (stackEmpty)
                                next_st.pc = st.pc;
                            else
                            begin
                                stackPop = 1'b1;
                                next_st.pc = stackTop + 32'h00000001;
                            end
                        end
                        `PFS_OP_COND_JUMP:
                        begin
                            if (cmdType == `PFS_COND_TIMEOUT && st.timeoutErr)
                                next_st.pc = cmdValue;
                        end
                        `PFS_OP_WAIT:
                        begin
                            if (cmdType <= `PFS_WAIT_REF_SEARCH)
                            begin
                                next_st.pc = st.pc;
                                next_st.done = 1'b0;
                                next_st.mode = PFS_WAIT;
                                next_st.busy = 1'b1;
                                next_st.waitType = cmdType;
                                next_st.waitMotor = cmdMotor;
                                next_st.waitCount = cmdCount;
                                next_st.tickCount = '0;
                                tickRestart = 1'b1;
                            end
                        end
                        default:
                            next_st.pc = st.pc + 32'h00000001;
                    endcase
                end
                else if (accept)
                begin
                    next_st.done = 1'b1;
                end
            end
            PFS_WAIT:
            begin
                if (tick)
                    next_st.tickCount = st.tickCount + 32'h00000001;
                if (st.waitType == `PFS_WAIT_TICKS)
                begin
                    if (ticksReached)
                    begin
                        next_st.mode = PFS_IDLE;
                        next_st.busy = 1'b0;
                    end
                end
                else if (condMet)
                begin
                    next_st.mode = PFS_IDLE;
                    next_st.busy = 1'b0;
                end
                else if (st.waitCount != '0 && ticksReached)
                begin
                    next_st.timeoutErr = 1'b1;
                    next_st.mode = PFS_IDLE;
                    next_st.busy = 1'b0;
                end
                if (next_st.mode == PFS_IDLE)
                begin
                    next_st.pc = st.pc + 32'h00000001;
                    next_st.done = 1'b1;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.mode <= PFS_IDLE;
            st.pc <= `PFS_PC_RESET;
        end
        else
            st <= next_st;
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------

    // All outputs straight from the state register
    assign pc = st.pc;
    assign cmdDone = st.done;
    assign waitBusy = st.busy;
    assign timeoutErrorFlag = st.timeoutErr;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------

    direct_mode_inert_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        accept && !standalone |=> $stable(st.pc) && st.done)
        else $error("direct mode command moved the counter");

    jump_load_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        accept && standalone && cmdOpcode == `PFS_OP_JUMP_ALWAYS
        |=> st.pc == $past(cmdValue))
        else $error("jump did not load the value field");

    call_push_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        accept && standalone && cmdOpcode == `PFS_OP_CALL_SUB && !stackFull
        |=> st.pc == $past(cmdValue)
        && stackDepth == $past(stackDepth) + 1'b1
        && stackTop == $past(st.pc))
        else $error("call did not save and jump");

    stack_depth_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        stackDepth <= (DW+1)'(DEPTH))
        else $error("return stack deeper than eight");

    call_full_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        accept && standalone && cmdOpcode == `PFS_OP_CALL_SUB && stackFull
        |=> $stable(st.pc) && stackDepth == (DW+1)'(DEPTH))
        else $error("call on full stack had an effect");

    return_pop_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        accept && standalone && cmdOpcode == `PFS_OP_RETURN_SUB && !stackEmpty
        |=> st.pc == $past(stackTop) + 32'h00000001
        && stackDepth == $past(stackDepth) - 1'b1)
        else $error("return did not pop");

    return_empty_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        accept && standalone && cmdOpcode == `PFS_OP_RETURN_SUB && stackEmpty
        |=> $stable(st.pc) && stackDepth == '0)
        else $error("return on empty stack had an effect");

    wait_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        st.busy ##1 st.busy |-> $stable(st.pc) && !st.done)
        else $error("counter moved during a wait");

    axis_end_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        st.busy && st.waitType != `PFS_WAIT_TICKS && condMet
        |=> !st.busy && st.done && st.pc == $past(st.pc) + 32'h00000001)
        else $error("met condition did not end the wait");

    no_timeout_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        st.busy && st.waitType != `PFS_WAIT_TICKS && st.waitCount == '0
        && !condMet |=> st.busy)
        else $error("wait without timeout ended early");

    timeout_sticky_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        st.timeoutErr && !clearError |=> st.timeoutErr)
        else $error("timeout flag dropped without clear");

    cond_timeout_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        accept && standalone && cmdOpcode == `PFS_OP_COND_JUMP
        && cmdType == `PFS_COND_TIMEOUT && st.timeoutErr
        |=> st.pc == $past(cmdValue))
        else $error("timeout branch not taken");
endmodule
`default_nettype wire

// ### hdl/pfs_tick_gen.sv
// Restartable divider that makes the wait tick pulse
`timescale 1ns/1ps
`default_nettype none
module pfs_tick_gen #(
    parameter int unsigned CYCLES = 1000000
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic restart, // Restart the tick period
    output logic tick // One-cycle tick pulse
);
    import pfs_pkg::*;

    localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

    typedef struct packed {
        logic [CW-1:0] count;
        logic tick;
    } pfs_tick_s;

    pfs_tick_s st;
    pfs_tick_s next_st;

    // Restart aligns the first tick to a whole period after wait start
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (restart)
        begin
            next_st.count = '0;
        end
        else if (st.count == CW'(CYCLES - 1))
        begin
            next_st.count = '0;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.count = st.count + CW'(1);
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;
endmodule
`default_nettype wire

// ### tb/pfs_axis_model.sv
// Axis status model: raises the armed axis status line after a programmed delay, its neighbour axis at once
`timescale 1ns/1ps
`default_nettype none
module pfs_axis_model (
    input wire logic sys_clk, // System clock
    input wire logic evGo, // Event armed
    input wire logic [2:0] evKind, // Wait type 1..4
    input wire logic [1:0] evAxis, // Axis that answers
    input wire logic [7:0] evDelay, // Cycles before answer
    output logic [3:0] targetReached, // Axis at target
    output logic [3:0] refSwitch, // Reference switch
    output logic [3:0] limitLeft, // Left limit switch
    output logic [3:0] limitRight, // Right limit switch
    output logic [3:0] refSearchDone // Search finished
);
    logic [7:0] count;
    logic [3:0] hit;
    // Cycles since arming, zero while idle
    always_ff @(posedge sys_clk)
    begin
        count <= evGo ? count + 8'h01 : 8'h00;
    end
    // Neighbour axis answers at once, so a wrong axis pick ends early
    always_comb
    begin
        hit = 4'h0;
        if (evGo)
        begin
            hit[evAxis + 2'h1] = 1'b1;
            hit[evAxis] = (count >= evDelay);
        end
    end
    // one status kind per wait type
    assign targetReached = (evKind == 3'h1) ? hit : 4'h0;
    assign refSwitch = (evKind == 3'h2) ? hit : 4'h0;
    assign refSearchDone = (evKind == 3'h4) ? hit : 4'h0;
    // even axes use the left switch, odd ones the right
    assign limitLeft = (evKind == 3'h3) ? (hit & 4'h5) : 4'h0;
    assign limitRight = (evKind == 3'h3) ? (hit & 4'ha) : 4'h0;
endmodule
`default_nettype wire

// ### tb/program_flow_sequencer_bench.sv
// Self-checking bench for the program flow sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pfs_map.svh"
module program_flow_sequencer_bench;
    import pfs_pkg::*;
    localparam int TC = 8;
    logic sysClk = 1'b0;
    logic rst = 1'b1;
    logic standalone = 1'b1;
    logic cmdValid = 1'b0;
    logic [7:0] cmdOpcode = 8'h00;
    logic [7:0] cmdType = 8'h00;
    logic [7:0] cmdMotor = 8'h00;
    pfs_word_t cmdValue = 32'h00000000;
    pfs_word_t accum = 32'h00000000;
    logic clearError = 1'b0;
    logic evGo = 1'b0;
    logic [2:0] evKind = 3'h0;
    logic [1:0] evAxis = 2'h0;
    logic [7:0] evDelay = 8'h00;
    logic [3:0] targetReached, refSwitch, limitLeft, limitRight, refSearchDone;
    pfs_word_t pc;
    logic cmdDone, waitBusy, timeoutErrorFlag;
    int miscompares = 0;
    int samplesChecked = 0;

    pfs_sequencer #(.AXES(4), .TICK_CYCLES(TC)) i_pfs_sequencer (
        .sys_clk(sysClk), .rst(rst), .standalone(standalone),
        .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdType(cmdType),
        .cmdMotor(cmdMotor), .cmdValue(cmdValue), .accum(accum),
        .clearError(clearError), .targetReached(targetReached),
        .refSwitch(refSwitch), .limitLeft(limitLeft),
        .limitRight(limitRight), .refSearchDone(refSearchDone), .pc(pc),
        .cmdDone(cmdDone), .waitBusy(waitBusy),
        .timeoutErrorFlag(timeoutErrorFlag));
    pfs_axis_model i_pfs_axis_model (
        .sys_clk(sysClk), .evGo(evGo), .evKind(evKind), .evAxis(evAxis),
        .evDelay(evDelay), .targetReached(targetReached),
        .refSwitch(refSwitch), .limitLeft(limitLeft),
        .limitRight(limitRight), .refSearchDone(refSearchDone));

    // Free-running 100 MHz clock
    always #5 sysClk = ~sysClk;

    task automatic report_and_stop();
        $display("checked %0d mismatched %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic checkWord(input string what, input pfs_word_t exp,
                             input pfs_word_t got);
        samplesChecked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkBit(input string what, input logic exp,
                            input logic got);
        samplesChecked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One command held for one edge, released at the next falling edge
    task automatic issue(input logic [7:0] op, input logic [7:0] ty,
                         input logic [7:0] mo, input pfs_word_t val);
        @(negedge sysClk);
        cmdValid = 1'b1;
        cmdOpcode = op;
        cmdType = ty;
        cmdMotor = mo;
        cmdValue = val;
        @(negedge sysClk);
        cmdValid = 1'b0;
    endtask

    // Non-wait command: done pulse and new counter one cycle later
    task automatic run(input logic [7:0] op, input logic [7:0] ty,
                       input pfs_word_t val, input pfs_word_t expPc);
        issue(op, ty, 8'h00, val);
        checkBit("done", 1'b1, cmdDone);
        checkWord("pc", expPc, pc);
    endtask

    // Bounded wait for the end of a wait command
    task automatic awaitDone(output int n);
        n = 1;
        while (cmdDone !== 1'b1 && n < 2000)
        begin
            @(negedge sysClk);
            n++;
        end
        if (n >= 2000)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask

    task automatic testFlow();
        pfs_word_t p0;
        p0 = 32'h1234abcd;
        run(`PFS_OP_JUMP_ALWAYS, 8'h5a, p0, p0);
        standalone = 1'b0;
        run(`PFS_OP_JUMP_ALWAYS, 8'h00, 32'h77, p0);
        run(`PFS_OP_CALL_SUB, 8'h00, 32'h88, p0);
        run(`PFS_OP_WAIT, 8'h00, 32'h5, p0);
        standalone = 1'b1;
        for (int i = 0; i < 8; i++)
            run(`PFS_OP_CALL_SUB, 8'h00, 32'h100 + i, 32'h100 + i);
        run(`PFS_OP_CALL_SUB, 8'h00, 32'h999, 32'h107);
        for (int i = 7; i > 0; i--)
            run(`PFS_OP_RETURN_SUB, 8'h00, 0, 32'h100 + i);
        run(`PFS_OP_RETURN_SUB, 8'h00, 0, p0 + 32'h1);
        run(`PFS_OP_RETURN_SUB, 8'h00, 0, p0 + 32'h1);
        // Unknown wait type behaves as an ordinary command
        run(`PFS_OP_WAIT, 8'h05, 32'h5, p0 + 32'h2);
        $display("test flow finished");
    endtask

    task automatic testTicks(input pfs_word_t val, input int ticks);
        pfs_word_t p;
        int n;
        logic ok;
        p = pc;
        issue(`PFS_OP_WAIT, `PFS_WAIT_TICKS, 8'h33, val);
        checkBit("busy", 1'b1, waitBusy);
        checkWord("held pc", p, pc);
        awaitDone(n);
        ok = (n >= ticks * TC) && (n <= ticks * TC + 3);
        checkBit("span", 1'b1, ok);
        checkWord("next pc", p + 32'h1, pc);
        checkBit("flag", 1'b0, timeoutErrorFlag);
        $display("test ticks finished");
    endtask

    task automatic testAxis(input int kind, input int axis, input int dly,
                            input pfs_word_t tmo);
        pfs_word_t p;
        int n;
        logic ok;
        p = pc;
        // Let one edge pass with the model disarmed so its count restarts
        @(negedge sysClk);
        evKind = 3'(kind);
        evAxis = 2'(axis);
        evDelay = 8'(dly);
        evGo = 1'b1;
        issue(`PFS_OP_WAIT, 8'(kind), 8'(axis), tmo);
        awaitDone(n);
        evGo = 1'b0;
        ok = (n >= dly) && (n <= dly + 6);
        checkBit("axis span", 1'b1, ok);
        checkWord("axis pc", p + 32'h1, pc);
        checkBit("axis flag", 1'b0, timeoutErrorFlag);
        $display("test axis finished");
    endtask

    task automatic testTimeout();
        pfs_word_t p;
        int n;
        p = pc;
        issue(`PFS_OP_WAIT, `PFS_WAIT_POS, 8'h00, 32'h2);
        awaitDone(n);
        checkBit("tmo span", 1'b1, n >= 2 * TC && n <= 2 * TC + 3);
        checkBit("tmo flag", 1'b1, timeoutErrorFlag);
        checkWord("tmo pc", p + 32'h1, pc);
        run(`PFS_OP_COND_JUMP, `PFS_COND_TIMEOUT, 32'h40, 32'h40);
        checkBit("sticky", 1'b1, timeoutErrorFlag);
        @(negedge sysClk);
        clearError = 1'b1;
        @(negedge sysClk);
        clearError = 1'b0;
        checkBit("cleared", 1'b0, timeoutErrorFlag);
        run(`PFS_OP_COND_JUMP, `PFS_COND_TIMEOUT, 32'h80, 32'h41);
        $display("test timeout finished");
    endtask

    // Main sequence: reset, then every scenario in turn
    initial
    begin
        repeat (5) @(negedge sysClk);
        rst = 1'b0;
        checkWord("reset pc", `PFS_PC_RESET, pc);
        checkBit("reset flag", 1'b0, timeoutErrorFlag);
        testFlow();
        testTicks(32'h3, 3);
        accum = 32'h2;
        testTicks(`PFS_VALUE_ACCUM, 2);
        for (int k = 1; k < 5; k++)
            testAxis(k, k - 1, 12, 32'd50);
        testAxis(3, 1, 12, 32'd50);
        testAxis(2, 3, 200, 32'h0);
        testTimeout();
        report_and_stop();
    end
endmodule
`default_nettype wire
